/* sim/fmed_host.sv */
/*
 * fmed_host: host model issuing single-byte register accesses.
 * Assumes the bench calls wr and rd one at a time.
 */
module fmed_host
	import fmed_pkg::*;
(
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic reg_rvalid_q,
	// answer never came
	output logic hang
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
		hang = 1'b0;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		// idle lines never show the last value
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		n = 0;
		while (reg_rvalid_q !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		hang = (n == 4);
		d = reg_rdata_q;
	endtask : rd
endmodule : fmed_host

/* sim/fmed_properties.sv */
/*
 * fmed_props: port assertions for fmed_top.
 * Assumes it is bound to every fmed_top instance.
 */
module fmed_props
	import fmed_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic reg_rvalid_q,
	// samples and interrupt settings
	input wire logic sample_valid,
	input wire logic motion_irq_enable,
	input wire logic motion_irq_route,
	// events
	input wire logic event_active,
	input wire logic irq_pin1_q,
	input wire logic irq_pin2_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire rd_src = reg_rd && reg_addr == FMED_SRC_ADDR;
	wire rd_cfg = reg_rd && reg_addr == FMED_CFG_ADDR;

	a_read_answer: assert property (reg_rd |=> reg_rvalid_q)
		else $error("read not answered");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_q))
		else $error("read data moved");
	a_src_gap: assert property (rd_src |=> !reg_rdata_q[FMED_SRC_ZERO_BIT])
		else $error("source bit 6 set");
	a_cfg_low_zero: assert property (rd_cfg |=> reg_rdata_q[2:0] == 3'h0)
		else $error("config low bits set");
	a_ea_in_src: assert property (rd_src && event_active |=> reg_rdata_q[FMED_SRC_EA_BIT])
		else $error("event missing in source");
	a_event_steady: assert property (!sample_valid && !reg_rd && !reg_wr |=> $stable(event_active))
		else $error("event moved without sample");
	a_event_on_sample: assert property ($rose(event_active) |-> $past(sample_valid))
		else $error("event set without sample");
	a_irq_pin1: assert property (event_active && motion_irq_enable && motion_irq_route
		|=> irq_pin1_q && !irq_pin2_q)
		else $error("pin1 not raised");
	a_irq_pin2: assert property (event_active && motion_irq_enable && !motion_irq_route
		|=> irq_pin2_q && !irq_pin1_q)
		else $error("pin2 not raised");
	a_irq_quiet: assert property (!(event_active && motion_irq_enable) |=> !irq_pin1_q && !irq_pin2_q)
		else $error("irq without event");

	c_event_set: cover property ($rose(event_active));
	c_src_event: cover property (rd_src && event_active);
	c_pin2: cover property (irq_pin2_q);
endmodule : fmed_props

bind fmed_top fmed_props u_props (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata_q,
	.reg_rvalid_q, .sample_valid, .motion_irq_enable, .motion_irq_route, .event_active,
	.irq_pin1_q, .irq_pin2_q);

/* sim/fmed_tb_top.sv */
/*
 * fmed_tb_top: self-checking bench for fmed_top.
 * Assumes fmed_host and the bound checker are compiled first.
 */
module fmed_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fmed_pkg::*;
	logic clk, sys_rst, sample_valid, debounce_mode, motion_irq_enable, motion_irq_route, hang;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q, dcnt;
	logic reg_wr, reg_rd, reg_rvalid_q, event_active, irq_pin1_q, irq_pin2_q;
	logic [FMED_AXES-1:0][7:0] accel;
	logic [FMED_THS_W-1:0] ths;
	int error_cnt, cmp_count;

	fmed_top u_dut (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_q,
		.reg_rvalid_q, .sample_valid, .accel, .threshold_value(ths), .debounce_mode,
		.debounce_count_value(dcnt), .motion_irq_enable, .motion_irq_route, .event_active,
		.irq_pin1_q, .irq_pin2_q);
	fmed_host u_host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_q, .reg_rvalid_q, .hang);

	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk8(input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: exp %h got %h", $time, e, g);
		end
	endtask : chk8

	task automatic chk1(input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: exp %h got %h", $time, e, g);
		end
	endtask : chk1

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		chk8(e, d);
	endtask : rdc

	// one sample pulse, then room for event and irq to land
	task automatic samp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
		@(posedge clk);
		#1;
		accel = {z, y, x};
		sample_valid = 1'b1;
		@(posedge clk);
		#1;
		sample_valid = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : samp

	////////////////////////////////////////////////////////////////
	task automatic s_regs();
		rdc(FMED_CFG_ADDR, 8'h00);
		rdc(FMED_SRC_ADDR, 8'h00);
		rdc(8'h17, 8'h00);
		u_host.wr(FMED_CFG_ADDR, 8'hff);
		rdc(FMED_CFG_ADDR, 8'hf8);
		u_host.wr(FMED_SRC_ADDR, 8'hff);
		rdc(FMED_SRC_ADDR, 8'h00);
	endtask : s_regs

	task automatic s_disabled();
		u_host.wr(FMED_CFG_ADDR, 8'h40);
		samp(8'h64, 8'h64, 8'h64);
		chk1(1'b0, event_active);
		rdc(FMED_SRC_ADDR, 8'h00);
		u_host.wr(FMED_CFG_ADDR, 8'h00);
		samp(8'h00, 8'h00, 8'h00);
		chk1(1'b0, event_active);
	endtask : s_disabled

	task automatic s_motion();
		u_host.wr(FMED_CFG_ADDR, 8'h48);
		dcnt = 8'h02;
		motion_irq_enable = 1'b1;
		motion_irq_route = 1'b1;
		samp(8'hf5, 8'h00, 8'h00);
		chk1(1'b0, event_active);
		samp(8'hf5, 8'h00, 8'h00);
		chk1(1'b1, event_active);
		chk1(1'b1, irq_pin1_q);
		rdc(FMED_SRC_ADDR, 8'h83);
		rdc(FMED_SRC_ADDR, 8'h83);
		samp(8'h0a, 8'h64, 8'h00);
		chk1(1'b1, event_active);
		rdc(FMED_SRC_ADDR, 8'h80);
		samp(8'h0a, 8'h00, 8'h00);
		chk1(1'b0, event_active);
	endtask : s_motion

	task automatic s_freefall();
		u_host.wr(FMED_CFG_ADDR, 8'h18);
		debounce_mode = 1'b1;
		motion_irq_route = 1'b0;
		samp(8'h0a, 8'hf6, 8'h64);
		chk1(1'b0, event_active);
		samp(8'h0a, 8'hf6, 8'h64);
		chk1(1'b1, event_active);
		chk1(1'b1, irq_pin2_q);
		rdc(FMED_SRC_ADDR, 8'h80);
		samp(8'h0a, 8'hf5, 8'h00);
		chk1(1'b0, event_active);
		rdc(FMED_SRC_ADDR, 8'h0c);
		samp(8'h0a, 8'h00, 8'h00);
		chk1(1'b0, event_active);
		samp(8'h0a, 8'h00, 8'h00);
		chk1(1'b1, event_active);
	endtask : s_freefall

	task automatic s_latched();
		u_host.wr(FMED_CFG_ADDR, 8'h48);
		samp(8'h00, 8'h00, 8'h00);
		u_host.wr(FMED_CFG_ADDR, 8'hc8);
		debounce_mode = 1'b0;
		samp(8'hec, 8'h00, 8'h00);
		samp(8'hec, 8'h00, 8'h00);
		chk1(1'b1, event_active);
		samp(8'h05, 8'h00, 8'h00);
		chk1(1'b1, event_active);
		rdc(FMED_SRC_ADDR, 8'h83);
		chk1(1'b0, event_active);
		rdc(FMED_SRC_ADDR, 8'h00);
		samp(8'h14, 8'h00, 8'h00);
		chk1(1'b0, event_active);
		samp(8'h14, 8'h00, 8'h00);
		chk1(1'b1, event_active);
		chk1(1'b1, irq_pin2_q);
		chk1(1'b0, irq_pin1_q);
		// event still active: dropping the enable must silence the pin
		motion_irq_enable = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk1(1'b0, irq_pin2_q);
	endtask : s_latched

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge hang) begin
		error_cnt++;
		conclude();
	end

	initial begin
		sys_rst = 1'b1;
		sample_valid = 1'b0;
		accel = '0;
		ths = 7'h0a;
		dcnt = 8'h00;
		debounce_mode = 1'b0;
		motion_irq_enable = 1'b0;
		motion_irq_route = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		s_regs();
		s_disabled();
		s_motion();
		s_freefall();
		s_latched();
		conclude();
	end
endmodule : fmed_tb_top

/* verilog/fmed_axis.sv */
/*
 * fmed_axis: magnitude compare of one axis sample against the threshold.
 * Assumes the sample is two's complement in threshold units and on clk.
 */
module fmed_axis
	import fmed_pkg::*;
#(
	parameter int ACC_W = 8
) (
	// sample and threshold
	input wire logic [ACC_W-1:0] accel,
	input wire logic [FMED_THS_W-1:0] threshold_value,
	// result
	output logic high,
	output logic negative
);

	initial begin
		if (ACC_W < FMED_THS_W + 1) begin
			$error("fmed_axis: ACC_W too narrow for the threshold");
		end
	end

	wire logic [ACC_W-1:0] neg_accel;
	wire logic [ACC_W-1:0] magnitude;
	wire logic [ACC_W-1:0] ths_ext;

	// negating in ACC_W bits gives the right magnitude even for the most negative code
	assign neg_accel = ACC_W'(~accel + 1'b1);
	assign negative = accel[ACC_W-1];
	assign magnitude = negative ? neg_accel : accel;
	assign ths_ext = {{(ACC_W-FMED_THS_W){1'b0}}, threshold_value};
	assign high = magnitude > ths_ext;

endmodule : fmed_axis

/* verilog/fmed_debounce.sv */
/*
 * fmed_debounce: saturating debounce counter stepped once per data sample.
 * Assumes sample_valid is a one-cycle pulse from logic on clk.
 */
module fmed_debounce
	import fmed_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic sample_valid,
	input wire logic condition,
	input wire logic debounce_mode,
	input wire logic [FMED_CNT_W-1:0] debounce_count_value,
	input wire logic clear,
	// count
	output logic [FMED_CNT_W-1:0] cnt_d,
	output logic [FMED_CNT_W-1:0] cnt_q
);

	wire logic at_limit;
	wire logic [FMED_CNT_W-1:0] cnt_up;
	wire logic [FMED_CNT_W-1:0] cnt_down;
	wire logic [FMED_CNT_W-1:0] cnt_step;

	assign at_limit = cnt_q >= debounce_count_value;
	assign cnt_up = at_limit ? debounce_count_value : FMED_CNT_W'(cnt_q + 1'b1);
	assign cnt_down = (cnt_q == '0) ? '0 : FMED_CNT_W'(cnt_q - 1'b1);
	// lapse: mode 1 drops to zero, mode 0 walks down one per sample
	assign cnt_step = condition ? cnt_up : (debounce_mode ? '0 : cnt_down);
	assign cnt_d = clear ? '0 : (sample_valid ? cnt_step : cnt_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule : fmed_debounce

/* verilog/fmed_pkg.sv */
/*
 * fmed_pkg: shared constants and types of the freefall/motion event detector.
 * Assumes the register port offsets are the byte addresses of the device map.
 */
package fmed_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [7:0] FMED_CFG_ADDR = 8'h15;
	localparam logic [7:0] FMED_SRC_ADDR = 8'h16;
	localparam logic [7:0] FMED_CFG_RST = 8'h00;
	localparam logic [7:0] FMED_SRC_RST = 8'h00;
	localparam logic [7:0] FMED_CFG_WMASK = 8'hf8;
	localparam logic [7:0] FMED_RD_UNMAPPED = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int FMED_CFG_LATCH_BIT = 7;
	localparam int FMED_CFG_OR_BIT = 6;
	localparam int FMED_CFG_Z_BIT = 5;
	localparam int FMED_CFG_Y_BIT = 4;
	localparam int FMED_CFG_X_BIT = 3;
	localparam int FMED_SRC_EA_BIT = 7;
	localparam int FMED_SRC_ZERO_BIT = 6;

	////////////////////////////////////////////////////////////////////////////
	// widths and axis indices
	localparam int FMED_THS_W = 7;
	localparam int FMED_CNT_W = 8;
	localparam int FMED_AXES = 3;
	localparam int FMED_AX_X = 0;
	localparam int FMED_AX_Y = 1;
	localparam int FMED_AX_Z = 2;

	////////////////////////////////////////////////////////////////////////////
	// register layouts, msb first
	typedef struct packed {
		logic event_latch_en;
		logic or_and_select;
		logic z_axis_enable;
		logic y_axis_enable;
		logic x_axis_enable;
		logic [2:0] zero;
	} fmed_cfg_t;

	typedef struct packed {
		logic high_flag;
		logic polarity;
	} fmed_axis_t;

	typedef struct packed {
		logic event_active;
		logic zero;
		fmed_axis_t z_axis;
		fmed_axis_t y_axis;
		fmed_axis_t x_axis;
	} fmed_src_t;

endpackage : fmed_pkg

/* verilog/fmed_top.sv */
/*
 * fmed_top: freefall/motion event detector with its config and source registers.
 * Assumes an I2C slave in front drives the register port and that samples,
 * threshold, count and routing bits come from logic on clk.
 */
module fmed_top
	import fmed_pkg::*;
#(
	parameter int ACC_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port behind the serial slave
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	output logic reg_rvalid_q,
	// samples at output data rate
	input wire logic sample_valid,
	input wire logic [FMED_AXES-1:0][ACC_W-1:0] accel,
	// settings held in neighbouring registers
	input wire logic [FMED_THS_W-1:0] threshold_value,
	input wire logic debounce_mode,
	input wire logic [FMED_CNT_W-1:0] debounce_count_value,
	input wire logic motion_irq_enable,
	input wire logic motion_irq_route,
	// event outputs
	output logic event_active,
	output logic irq_pin1_q,
	output logic irq_pin2_q
);

	initial begin
		if (ACC_W < FMED_THS_W + 1) begin
			$error("fmed_top: ACC_W too narrow for the threshold");
		end
		// the flag packing below is written for three axes and byte-wide registers
		if (FMED_AXES != 3) begin
			$error("fmed_top: FMED_AXES must be 3");
		end
		if ($bits(fmed_cfg_t) != 8 || $bits(fmed_src_t) != 8) begin
			$error("fmed_top: register layouts must be one byte");
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [FMED_AXES-1:0] axis_enables(input fmed_cfg_t cfg);
		axis_enables = {cfg.z_axis_enable, cfg.y_axis_enable, cfg.x_axis_enable};
	endfunction : axis_enables

	function automatic logic [5:0] pack_axes(input fmed_axis_t [FMED_AXES-1:0] ax);
		pack_axes = {ax[FMED_AX_Z], ax[FMED_AX_Y], ax[FMED_AX_X]};
	endfunction : pack_axes

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
		addr_hit = addr == target;
	endfunction : addr_hit

	// one route bit steers the event to exactly one of the two pins
	function automatic logic route_pin(input logic live, input logic route, input logic want);
		route_pin = live & (route == want);
	endfunction : route_pin

	////////////////////////////////////////////////////////////////////////////
	// registers

	fmed_cfg_t cfg_q;
	fmed_cfg_t cfg_d;
	logic ea_q;
	logic ea_d;
	fmed_axis_t [FMED_AXES-1:0] flags_q;
	fmed_axis_t [FMED_AXES-1:0] flags_d;

	////////////////////////////////////////////////////////////////////////////
	// register port decode

	wire logic cfg_sel;
	wire logic src_sel;
	wire logic cfg_write;
	wire logic src_read;

	assign cfg_sel = addr_hit(reg_addr, FMED_CFG_ADDR);
	assign src_sel = addr_hit(reg_addr, FMED_SRC_ADDR);
	assign cfg_write = reg_wr & cfg_sel;
	assign src_read = reg_rd & src_sel;
	// low three bits are not stored and read zero
	assign cfg_d = cfg_write ? fmed_cfg_t'(reg_wdata & FMED_CFG_WMASK) : cfg_q;

	////////////////////////////////////////////////////////////////////////////
	// per-axis compare

	wire logic [FMED_AXES-1:0] ax_en;
	wire logic [FMED_AXES-1:0] ax_high;
	wire logic [FMED_AXES-1:0] ax_neg;
	fmed_axis_t [FMED_AXES-1:0] live_flags;

	assign ax_en = axis_enables(cfg_q);

	genvar gi;
	generate
		for (gi = 0; gi < FMED_AXES; gi++) begin : g_axis
			fmed_axis #(
				.ACC_W(ACC_W)
			) u_axis (
				.accel(accel[gi]),
				.threshold_value(threshold_value),
				.high(ax_high[gi]),
				.negative(ax_neg[gi])
			);
			// polarity only means something while the axis is high
			assign live_flags[gi].high_flag = ax_high[gi] & ax_en[gi];
			assign live_flags[gi].polarity = ax_high[gi] & ax_neg[gi] & ax_en[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// axis combination

	wire logic any_en;
	wire logic freefall_cond;
	wire logic motion_cond;
	wire logic condition;

	// freefall over no axes would be vacuously true, hence any_en
	assign any_en = |ax_en;
	assign freefall_cond = any_en & (&(~ax_high | ~ax_en));
	assign motion_cond = |(ax_high & ax_en);
	assign condition = any_en & (cfg_q.or_and_select ? motion_cond : freefall_cond);

	////////////////////////////////////////////////////////////////////////////
	// debounce

	wire logic latch_on;
	wire logic ea_set;
	wire logic latched_read;
	wire logic cnt_clear;
	wire logic [FMED_CNT_W-1:0] cnt_d;
	wire logic [FMED_CNT_W-1:0] cnt_q;

	assign latch_on = cfg_q.event_latch_en;
	// a read that meets a new event loses: the event and its count survive
	assign latched_read = latch_on & src_read & ~ea_set;
	// unlatched reads leave the count alone, so polling cannot shorten an event
	assign cnt_clear = latched_read;

	fmed_debounce u_debounce (
		.clk(clk),
		.sys_rst(sys_rst),
		.sample_valid(sample_valid),
		.condition(condition),
		.debounce_mode(debounce_mode),
		.debounce_count_value(debounce_count_value),
		.clear(cnt_clear),
		.cnt_d(cnt_d),
		.cnt_q(cnt_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// event-active flag

	wire logic unlatched_clr;
	wire logic ea_clr;
	wire logic lapse_sample;
	wire logic cnt_at_max;
	wire logic at_count;
	wire logic [FMED_CNT_W-1:0] cnt_inc;

	// judged on the uncleared step: the read clear itself depends on ea_set
	assign cnt_inc = FMED_CNT_W'(cnt_q + 1'b1);
	assign cnt_at_max = cnt_q >= debounce_count_value;
	assign at_count = cnt_at_max | (cnt_inc == debounce_count_value);
	assign ea_set = sample_valid & condition & at_count;
	assign lapse_sample = sample_valid & ~condition;
	// mode 0 holds until the count is walked back to zero; mode 1 drops at once
	assign unlatched_clr = lapse_sample & (debounce_mode | (cnt_d == '0));
	assign ea_clr = latch_on ? latched_read : unlatched_clr;
	assign ea_d = ea_set | (ea_q & ~ea_clr);

	////////////////////////////////////////////////////////////////////////////
	// axis flags

	wire logic frozen;
	wire logic flag_load;

	// latch mode only: unlatched flags keep following the live status
	assign frozen = latch_on & ea_q;
	assign flag_load = sample_valid & ~frozen;
	assign flags_d = latched_read ? '0 : (flag_load ? live_flags : flags_q);

	////////////////////////////////////////////////////////////////////////////
	// read data

	fmed_src_t src_view;
	wire logic [5:0] flag_bits;
	wire logic [5:0] en_mask;
	wire logic [7:0] rd_mux;
	wire logic [7:0] reg_rdata_d;
	wire logic reg_rvalid_d;

	assign en_mask = {{2{ax_en[FMED_AX_Z]}}, {2{ax_en[FMED_AX_Y]}}, {2{ax_en[FMED_AX_X]}}};
	assign flag_bits = pack_axes(flags_q) & en_mask;
	assign src_view = fmed_src_t'({ea_q, 1'b0, flag_bits});
	// unmapped addresses read zero; the rest of the map lives outside this block
	assign rd_mux = src_sel ? src_view : (cfg_sel ? cfg_q : FMED_RD_UNMAPPED);
	assign reg_rdata_d = reg_rd ? rd_mux : reg_rdata_q;
	assign reg_rvalid_d = reg_rd;

	////////////////////////////////////////////////////////////////////////////
	// interrupt gating

	wire logic irq_live;
	wire logic irq_pin1_d;
	wire logic irq_pin2_d;

	assign irq_live = ea_q & motion_irq_enable;
	assign irq_pin1_d = route_pin(irq_live, motion_irq_route, 1'b1);
	assign irq_pin2_d = route_pin(irq_live, motion_irq_route, 1'b0);
	assign event_active = ea_q;

	////////////////////////////////////////////////////////////////////////////
	// state

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_q <= fmed_cfg_t'(FMED_CFG_RST);
		end else begin
			cfg_q <= cfg_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ea_q <= FMED_SRC_RST[FMED_SRC_EA_BIT];
		end else begin
			ea_q <= ea_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	// read data holds between reads so a slow serial slave can fetch it late
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= reg_rdata_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rvalid_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_pin1_q <= 1'b0;
			irq_pin2_q <= 1'b0;
		end else begin
			irq_pin1_q <= irq_pin1_d;
			irq_pin2_q <= irq_pin2_d;
		end
	end

endmodule : fmed_top
